// ---- rqp_pkg.sv ----
package rqp_pkg;

	// ****************************************************************
	// descriptor field positions
	// ****************************************************************
	localparam int DESC_TYPE_LSB = 75;
	localparam int DESC_TAG_LSB  = 96;
	localparam int TYPE_W        = 4;
	localparam int TAG_W         = 6;
	localparam int TAG_COUNT     = 64;
	localparam int OFF_W         = 3;
	localparam int BE_W          = 4;
	localparam int KEEP_W        = 8;

	// ****************************************************************
	// request type codes
	// ****************************************************************
	localparam logic [3:0] TYPE_MEM_RD  = 4'h0;
	localparam logic [3:0] TYPE_MEM_WR  = 4'h1;
	localparam logic [3:0] TYPE_IO_RD   = 4'h2;
	localparam logic [3:0] TYPE_IO_WR   = 4'h3;
	localparam logic [3:0] TYPE_FADD    = 4'h4;
	localparam logic [3:0] TYPE_SWAP    = 4'h5;
	localparam logic [3:0] TYPE_CAS     = 4'h6;
	localparam logic [3:0] TYPE_LOCK_RD = 4'h7;
	localparam logic [3:0] TYPE_CFG0_RD = 4'h8;
	localparam logic [3:0] TYPE_CFG0_WR = 4'h9;
	localparam logic [3:0] TYPE_CFG1_RD = 4'hA;
	localparam logic [3:0] TYPE_CFG1_WR = 4'hB;
	localparam logic [3:0] TYPE_MSG     = 4'hC;
	localparam logic [3:0] TYPE_MSG_VD  = 4'hD;
	localparam logic [3:0] TYPE_MSG_ATS = 4'hE;

	// ****************************************************************
	// constant values
	// ****************************************************************
	localparam logic [3:0] BE_ALL         = 4'hF;
	localparam logic [3:0] BE_NONE        = 4'h0;
	localparam logic [7:0] KEEP_DESC_64   = 8'h03;
	localparam logic [7:0] KEEP_DESC_WIDE = 8'h0F;
	localparam logic [1:0] DESC_BEAT_64   = 2'h1;
	localparam logic [1:0] DESC_BEAT_WIDE = 2'h0;
	localparam logic [1:0] CNT_FIRST      = 2'h0;
	localparam logic [1:0] CNT_PAYLOAD    = 2'h2;
	localparam logic [2:0] OFF_ZERO       = 3'h0;

	// ****************************************************************
	// state of the request port
	// ****************************************************************
	typedef struct packed {
		logic                          ready;
		logic [1:0]                    cnt;
		logic [TYPE_W-1:0]             rtype;
		logic [OFF_W-1:0]              off;
		logic [BE_W-1:0]               hbe;
		logic [BE_W-1:0]               tbe;
		logic                          abort;
		logic                          bad;
		logic [TAG_COUNT-1:0]          busy;
		logic [TAG_COUNT-1:0][OFF_W-1:0] offs;
		logic [TAG_W-1:0]              tag;
		logic                          tag_stb;
		logic                          pkt_end;
		logic                          pkt_null;
		logic [TYPE_W-1:0]             pkt_type;
		logic [BE_W-1:0]               pkt_hbe;
		logic [BE_W-1:0]               pkt_tbe;
		logic                          err;
		logic [OFF_W-1:0]              cpl_align;
		logic                          full;
	} rqp_state_t;

	// ****************************************************************
	// type classes
	// ****************************************************************
	function automatic logic rqp_is_np(input logic [3:0] t);
		rqp_is_np = (t != TYPE_MEM_WR) && (t < TYPE_MSG);
	endfunction : rqp_is_np

	function automatic logic rqp_is_read(input logic [3:0] t);
		rqp_is_read = (t == TYPE_MEM_RD) || (t == TYPE_IO_RD) ||
			(t == TYPE_LOCK_RD) || (t == TYPE_CFG0_RD) ||
			(t == TYPE_CFG1_RD);
	endfunction : rqp_is_read

	function automatic logic rqp_is_atomic(input logic [3:0] t);
		rqp_is_atomic = (t == TYPE_FADD) || (t == TYPE_SWAP) ||
			(t == TYPE_CAS);
	endfunction : rqp_is_atomic

	function automatic logic rqp_is_msg(input logic [3:0] t);
		rqp_is_msg = (t >= TYPE_MSG) && (t <= TYPE_MSG_ATS);
	endfunction : rqp_is_msg

endpackage : rqp_pkg

// ---- rqp_request_port.sv ----
`timescale 1ns/1ps

module rqp_request_port #(
	parameter int DATA_W       = 128,
	parameter bit USER_TAG     = 1'b0,
	parameter bit ADDR_ALIGNED = 1'b0,
	parameter bit IS_ENDPOINT  = 1'b1
) (
	input  wire logic                           CLOCK_I,
	input  wire logic                           RST_I,
	input  wire logic                           REQ_VALID_I,
	output      logic                           REQ_READY_O,
	input  wire logic [DATA_W-1:0]              REQ_DATA_I,
	input  wire logic                           REQ_LAST_I,
	input  wire logic [rqp_pkg::KEEP_W-1:0]     REQ_KEEP_I,
	input  wire logic [rqp_pkg::BE_W-1:0]       REQ_HEAD_BE_I,
	input  wire logic [rqp_pkg::BE_W-1:0]       REQ_TAIL_BE_I,
	input  wire logic [rqp_pkg::OFF_W-1:0]      REQ_ADDR_OFFSET_I,
	input  wire logic                           REQ_ABORT_I,
	output      logic [rqp_pkg::TAG_W-1:0]      TAG_OUT_O,
	output      logic                           TAG_STROBE_O,
	output      logic                           PKT_END_O,
	output      logic                           PKT_NULL_O,
	output      logic [rqp_pkg::TYPE_W-1:0]     PKT_TYPE_O,
	output      logic [rqp_pkg::BE_W-1:0]       PKT_HEAD_BE_O,
	output      logic [rqp_pkg::BE_W-1:0]       PKT_TAIL_BE_O,
	output      logic                           INTERNAL_ERR_O,
	input  wire logic                           CPL_FREE_I,
	input  wire logic [rqp_pkg::TAG_W-1:0]      CPL_TAG_I,
	input  wire logic [rqp_pkg::TAG_W-1:0]      CPL_LOOKUP_TAG_I,
	output      logic [rqp_pkg::OFF_W-1:0]      CPL_ALIGN_O,
	output      logic                           TABLE_FULL_O
);

	// ****************************************************************
	// elaboration checks and width dependent constants
	// ****************************************************************
	if (DATA_W != 64 && DATA_W != 128 && DATA_W != 256)
	begin : g_bad_width
		$error("data width must be 64, 128 or 256");
	end

	localparam bit NARROW = (DATA_W == 64);
	localparam int TYPE_POS = NARROW ?
		rqp_pkg::DESC_TYPE_LSB - 64 : rqp_pkg::DESC_TYPE_LSB;
	localparam int TAG_POS = NARROW ?
		rqp_pkg::DESC_TAG_LSB - 64 : rqp_pkg::DESC_TAG_LSB;
	localparam logic [1:0] DESC_BEAT = NARROW ?
		rqp_pkg::DESC_BEAT_64 : rqp_pkg::DESC_BEAT_WIDE;
	localparam logic [7:0] KEEP_DESC = NARROW ?
		rqp_pkg::KEEP_DESC_64 : rqp_pkg::KEEP_DESC_WIDE;

	// ****************************************************************
	// state and next state
	// ****************************************************************
	rqp_pkg::rqp_state_t s;
	rqp_pkg::rqp_state_t next_s;

	logic                         take;
	logic                         at_desc;
	logic                         np_take;
	logic                         abort_now;
	logic                         bad_now;
	logic [rqp_pkg::TYPE_W-1:0]   cur_type;
	logic [rqp_pkg::OFF_W-1:0]    off_now;
	logic [rqp_pkg::BE_W-1:0]     hbe_now;
	logic [rqp_pkg::BE_W-1:0]     tbe_now;
	logic [rqp_pkg::TAG_W-1:0]    pick;
	logic [rqp_pkg::TAG_W-1:0]    new_tag;

	always_comb
	begin
		next_s    = s;
		take      = REQ_VALID_I && s.ready;
		at_desc   = (s.cnt == DESC_BEAT);
		cur_type  = at_desc ? REQ_DATA_I[TYPE_POS +: rqp_pkg::TYPE_W] :
			s.rtype;
		hbe_now   = (s.cnt == rqp_pkg::CNT_FIRST) ? REQ_HEAD_BE_I : s.hbe;
		tbe_now   = (s.cnt == rqp_pkg::CNT_FIRST) ? REQ_TAIL_BE_I : s.tbe;
		// completion start lane comes from the request offset when ADDR_ALIGNED is set, else zero
		off_now   = rqp_pkg::OFF_ZERO;
		if (ADDR_ALIGNED)
		begin
			off_now = (s.cnt == rqp_pkg::CNT_FIRST) ?
				REQ_ADDR_OFFSET_I : s.off;
		end
		// lowest free tag
		pick = '0;
		for (int i = rqp_pkg::TAG_COUNT - 1; i >= 0; i--)
		begin
			if (!s.busy[i])
			begin
				pick = rqp_pkg::TAG_W'(i);
			end
		end
		new_tag = USER_TAG ? REQ_DATA_I[TAG_POS +: rqp_pkg::TAG_W] :
			pick;
		np_take   = take && at_desc && rqp_pkg::rqp_is_np(cur_type);
		abort_now = s.abort || REQ_ABORT_I;
		bad_now   = s.bad;

		next_s.tag_stb = 1'b0;
		next_s.pkt_end = 1'b0;
		next_s.err     = 1'b0;

		// ************************************************************
		// split completion table
		// ************************************************************
		if (CPL_FREE_I)
		begin
			next_s.busy[CPL_TAG_I] = 1'b0;
		end
		if (np_take)
		begin
			next_s.busy[new_tag] = 1'b1;
			next_s.offs[new_tag] = off_now;
			if (!USER_TAG)
			begin
				next_s.tag     = new_tag;
				next_s.tag_stb = 1'b1;
			end
		end
		next_s.cpl_align = s.offs[CPL_LOOKUP_TAG_I];

		// ************************************************************
		// request packet tracking
		// ************************************************************
		if (take)
		begin
			if (s.cnt == rqp_pkg::CNT_FIRST)
			begin
				next_s.off = REQ_ADDR_OFFSET_I;
				next_s.hbe = REQ_HEAD_BE_I;
				next_s.tbe = REQ_TAIL_BE_I;
			end
			if (at_desc)
			begin
				next_s.rtype = cur_type;
			end
			// descriptor lanes must all be kept
			if (s.cnt <= DESC_BEAT &&
				(REQ_KEEP_I & KEEP_DESC) != KEEP_DESC)
			begin
				bad_now = 1'b1;
			end
			// reads end on the descriptor beat
			if (at_desc && rqp_pkg::rqp_is_read(cur_type) && !REQ_LAST_I)
			begin
				bad_now = 1'b1;
			end
			// packet shorter than its descriptor
			if (s.cnt < DESC_BEAT && REQ_LAST_I)
			begin
				bad_now = 1'b1;
			end
			// dword mode: payload lanes follow the descriptor with no gap
			if (!ADDR_ALIGNED &&
				(REQ_KEEP_I & (REQ_KEEP_I + 8'h01)) != 8'h00)
			begin
				bad_now = 1'b1;
			end
			if (REQ_LAST_I)
			begin
				next_s.pkt_end  = 1'b1;
				next_s.pkt_null = abort_now || bad_now;
				next_s.err      = IS_ENDPOINT && abort_now;
				next_s.pkt_type = cur_type;
				next_s.pkt_hbe  = hbe_now;
				next_s.pkt_tbe  = tbe_now;
				if (rqp_pkg::rqp_is_msg(cur_type))
				begin
					next_s.pkt_hbe = rqp_pkg::BE_NONE;
					next_s.pkt_tbe = rqp_pkg::BE_NONE;
				end
				else if (rqp_pkg::rqp_is_atomic(cur_type))
				begin
					next_s.pkt_hbe = rqp_pkg::BE_ALL;
					next_s.pkt_tbe = rqp_pkg::BE_ALL;
				end
				next_s.cnt   = rqp_pkg::CNT_FIRST;
				next_s.abort = 1'b0;
				next_s.bad   = 1'b0;
			end
			else
			begin
				if (s.cnt != rqp_pkg::CNT_PAYLOAD)
				begin
					next_s.cnt = 2'(s.cnt + 2'h1);
				end
				next_s.abort = abort_now;
				next_s.bad   = bad_now;
			end
		end

		next_s.full  = &next_s.busy;
		// stall only the descriptor beat while the table is full and USER_TAG is clear
		next_s.ready = USER_TAG || !next_s.full ||
			(next_s.cnt != DESC_BEAT);
	end

	always_ff @(posedge CLOCK_I)
	begin
		if (RST_I)
		begin
			s <= '0;
		end
		else
		begin
			s <= next_s;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign REQ_READY_O    = s.ready;
	assign TAG_OUT_O      = s.tag;
	assign TAG_STROBE_O   = s.tag_stb;
	assign PKT_END_O      = s.pkt_end;
	assign PKT_NULL_O     = s.pkt_null;
	assign PKT_TYPE_O     = s.pkt_type;
	assign PKT_HEAD_BE_O  = s.pkt_hbe;
	assign PKT_TAIL_BE_O  = s.pkt_tbe;
	assign INTERNAL_ERR_O = s.err;
	assign CPL_ALIGN_O    = s.cpl_align;
	assign TABLE_FULL_O   = s.full;

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (RST_I);

	a_full_stall: assert property (
		(!USER_TAG && REQ_READY_O && s.cnt == DESC_BEAT) |-> !(&s.busy)
	) else $error("ready high on descriptor beat with table full");

	a_tag_report: assert property (
		(np_take && !USER_TAG) |=> (TAG_STROBE_O && s.busy[TAG_OUT_O])
	) else $error("accepted request got no busy tag");

	a_tag_cause: assert property (
		TAG_STROBE_O |-> $past(np_take && !USER_TAG)
	) else $error("tag strobe without a request");

	a_tag_order: assert property (
		(np_take && !USER_TAG) ##1 (np_take && !USER_TAG)
			|=> (TAG_STROBE_O && $past(TAG_STROBE_O) &&
			TAG_OUT_O != $past(TAG_OUT_O))
	) else $error("back to back requests share a tag");

	a_posted_tag: assert property (
		(take && at_desc && !rqp_pkg::rqp_is_np(cur_type))
			|=> !TAG_STROBE_O
	) else $error("tag strobe for a posted request");

	a_tag_free: assert property (
		(CPL_FREE_I && s.busy[CPL_TAG_I] && !np_take)
			|=> !s.busy[$past(CPL_TAG_I)]
	) else $error("completed tag not returned to pool");

	a_abort_now: assert property (
		(take && REQ_ABORT_I && REQ_LAST_I)
			|=> (PKT_END_O && PKT_NULL_O)
	) else $error("abort on last beat not nullified");

	a_abort_sticky: assert property (
		(take && REQ_ABORT_I && !REQ_LAST_I)
			##1 (take && REQ_LAST_I && !REQ_ABORT_I)
			|=> (PKT_NULL_O && INTERNAL_ERR_O == IS_ENDPOINT)
	) else $error("abort not held until packet end");

	a_err_report: assert property (
		INTERNAL_ERR_O |-> (PKT_END_O && PKT_NULL_O && IS_ENDPOINT)
	) else $error("internal error without aborted packet");

	a_read_only: assert property (
		(take && at_desc && rqp_pkg::rqp_is_read(cur_type) && !REQ_LAST_I)
			##1 (take && REQ_LAST_I) |=> PKT_NULL_O
	) else $error("read with payload beats not nullified");

	a_msg_be: assert property (
		(take && REQ_LAST_I && rqp_pkg::rqp_is_msg(cur_type))
			|=> (PKT_HEAD_BE_O == rqp_pkg::BE_NONE &&
			PKT_TAIL_BE_O == rqp_pkg::BE_NONE)
	) else $error("message packet reported byte enables");

	a_atomic_be: assert property (
		(take && REQ_LAST_I && rqp_pkg::rqp_is_atomic(cur_type))
			|=> (PKT_HEAD_BE_O == rqp_pkg::BE_ALL &&
			PKT_TAIL_BE_O == rqp_pkg::BE_ALL)
	) else $error("atomic packet lost its byte enables");

	a_beat_moves: assert property (
		PKT_END_O |-> $past(REQ_VALID_I && REQ_READY_O && REQ_LAST_I)
	) else $error("packet ended without a handshake");

	a_reset_clear: assert property (
		$past(RST_I) |-> (s.busy == '0 && !TAG_STROBE_O && !PKT_END_O)
	) else $error("state not cleared by reset");

	a_ready_reset: assert property (
		disable iff (1'b0) RST_I |=> !REQ_READY_O
	) else $error("ready raised during reset");

	c_tag_given: cover property (
		np_take ##1 TAG_STROBE_O
	);

	c_abort_end: cover property (
		(take && REQ_ABORT_I) ##[1:8] (PKT_END_O && PKT_NULL_O)
	);

	c_full_stall: cover property (
		TABLE_FULL_O && REQ_VALID_I && !REQ_READY_O
	);

	c_tag_reuse: cover property (
		CPL_FREE_I ##1 np_take
	);

	c_msg_end: cover property (
		(take && REQ_LAST_I && rqp_pkg::rqp_is_msg(cur_type))
			##1 PKT_END_O
	);

endmodule : rqp_request_port

// ---- rqp_user_model.sv ----
`timescale 1ns/1ps
// ****
// user logic issuing requests
// ****
module rqp_user_model #(
	parameter int DATA_W = 128
) (
	input  wire logic                       clk_i,
	input  wire logic                       ready_i,
	output      logic                       valid_o,
	output      logic [DATA_W-1:0]          data_o,
	output      logic                       last_o,
	output      logic [rqp_pkg::KEEP_W-1:0] keep_o,
	output      logic [rqp_pkg::BE_W-1:0]   hbe_o,
	output      logic [rqp_pkg::BE_W-1:0]   tbe_o,
	output      logic [rqp_pkg::OFF_W-1:0]  off_o,
	output      logic                       abort_o
);
	initial
	begin
		valid_o = 1'b0;
		data_o  = '0;
		last_o  = 1'b0;
		keep_o  = 8'h00;
		hbe_o   = 4'h0;
		tbe_o   = 4'h0;
		off_o   = 3'h0;
		abort_o = 1'b0;
	end

	// hold the beat until it is taken
	task automatic take;
		do
			@(posedge clk_i);
		while (ready_i !== 1'b1);
	endtask : take

	task automatic send(
		input logic [3:0]        typ,
		input logic [3:0]        hbe,
		input logic [3:0]        tbe,
		input logic [2:0]        off,
		input logic              pay,
		input logic              abt,
		input logic [DATA_W-1:0] d
	);
		@(posedge clk_i);
		valid_o <= 1'b1;
		data_o  <= {d[DATA_W-1:79], typ, d[74:0]};
		last_o  <= !pay;
		keep_o  <= 8'h0F;
		hbe_o   <= hbe;
		tbe_o   <= tbe;
		off_o   <= off;
		abort_o <= abt;
		take();
		if (pay)
		begin
			data_o  <= ~d;
			last_o  <= 1'b1;
			abort_o <= 1'b0;
			take();
		end
		valid_o <= 1'b0;
		data_o  <= ~data_o;
		last_o  <= 1'b0;
		abort_o <= 1'b0;
		keep_o  <= 8'h00;
	endtask : send
endmodule : rqp_user_model

// ---- rqp_request_port_tb_top.sv ----
`timescale 1ns/1ps
// ****
// bench for the request port
// ****
module rqp_request_port_tb_top;
	logic         clk, rst, valid, ready, last, abort, tstb, pend, pnull;
	logic         ierr, cfree, full;
	logic [127:0] data;
	logic [7:0]   keep;
	logic [3:0]   hbe, tbe, ptype, phbe, ptbe;
	logic [2:0]   off, calign;
	logic [5:0]   tag, ctag, ltag;
	logic [63:0]  busy;
	logic [2:0]   offs [64];
	logic [5:0]   tagq [$];
	logic [12:0]  pktq [$];
	int           seed = 16860;
	int           failures, total_checks, cycles, errs;

	rqp_request_port #(.ADDR_ALIGNED(1'b1)) DUT (
		.CLOCK_I(clk), .RST_I(rst), .REQ_VALID_I(valid),
		.REQ_READY_O(ready), .REQ_DATA_I(data), .REQ_LAST_I(last),
		.REQ_KEEP_I(keep), .REQ_HEAD_BE_I(hbe), .REQ_TAIL_BE_I(tbe),
		.REQ_ADDR_OFFSET_I(off), .REQ_ABORT_I(abort), .TAG_OUT_O(tag),
		.TAG_STROBE_O(tstb), .PKT_END_O(pend), .PKT_NULL_O(pnull),
		.PKT_TYPE_O(ptype), .PKT_HEAD_BE_O(phbe), .PKT_TAIL_BE_O(ptbe),
		.INTERNAL_ERR_O(ierr), .CPL_FREE_I(cfree), .CPL_TAG_I(ctag),
		.CPL_LOOKUP_TAG_I(ltag), .CPL_ALIGN_O(calign), .TABLE_FULL_O(full));

	rqp_user_model u_user (
		.clk_i(clk), .ready_i(ready), .valid_o(valid), .data_o(data),
		.last_o(last), .keep_o(keep), .hbe_o(hbe), .tbe_o(tbe),
		.off_o(off), .abort_o(abort));

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ****
	// checking and expectations
	// ****
	task automatic final_report;
		if (failures == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : final_report

	task automatic chk_val(input string n, input logic [15:0] e, g);
		total_checks++;
		if (g !== e)
		begin
			$display("mismatch %s expected %h seen %h", n, e, g);
			failures++;
		end
	endtask : chk_val

	task automatic chk_pkt(input logic [12:0] g);
		logic [12:0] e;
		e = (pktq.size() > 0) ? pktq.pop_front() : 'x;
		chk_val("packet", 16'(e), 16'(g));
	endtask : chk_pkt

	task automatic chk_tag(input logic [5:0] g);
		logic [5:0] e;
		e = (tagq.size() > 0) ? tagq.pop_front() : 'x;
		chk_val("tag", 16'(e), 16'(g));
	endtask : chk_tag

	function automatic logic [5:0] f_lowest(input logic [63:0] b);
		f_lowest = 6'h00;
		for (int i = 63; i >= 0; i--)
			if (!b[i])
				f_lowest = 6'(i);
	endfunction : f_lowest

	function automatic logic [3:0] f_be(input logic [3:0] t, be);
		if (t >= rqp_pkg::TYPE_MSG)
			f_be = 4'h0;
		else if (t >= rqp_pkg::TYPE_FADD && t <= rqp_pkg::TYPE_CAS)
			f_be = 4'hF;
		else
			f_be = be;
	endfunction : f_be

	task automatic req(input logic [3:0] t, h, l, input logic [2:0] o,
		input logic pay, abt);
		logic [5:0]   k;
		logic [127:0] d;
		d = {$random(seed), $random(seed), $random(seed), $random(seed)};
		pktq.push_back({abt, t, f_be(t, h), f_be(t, l)});
		if (t != rqp_pkg::TYPE_MEM_WR && t < rqp_pkg::TYPE_MSG)
		begin
			k = f_lowest(busy);
			busy[k] = 1'b1;
			offs[k] = o;
			tagq.push_back(k);
		end
		u_user.send(t, h, l, o, pay, abt, d);
	endtask : req

	always @(posedge clk)
	begin
		cycles++;
		if (!rst && pend === 1'b1)
			chk_pkt({pnull, ptype, phbe, ptbe});
		if (!rst && tstb === 1'b1)
			chk_tag(tag);
		if (ierr === 1'b1)
			errs++;
		if (cycles == 5000)
		begin
			failures++;
			final_report();
		end
	end

	// ****
	// main sequence
	// ****
	initial
	begin
		rst = 1'b1;
		cfree = 1'b0;
		ctag = 6'h00;
		ltag = 6'h00;
		busy = '0;
		repeat (6) @(posedge clk);
		chk_val("ready", 16'h0000, 16'(ready));
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		chk_val("ready", 16'h0001, 16'(ready));
		for (int t = 0; t < 15; t++)
			req(4'(t), 4'($random(seed)), 4'($random(seed)),
				(t >= 12) ? 3'h0 : 3'($random(seed)),
				!(t inside {0, 2, 7, 8, 10}), 1'b0);
		req(rqp_pkg::TYPE_MEM_RD, 4'h0, 4'h0, 3'h5, 1'b0, 1'b0);
		req(rqp_pkg::TYPE_MEM_WR, 4'hF, 4'hF, 3'h0, 1'b1, 1'b1);
		while (busy !== '1)
			req(rqp_pkg::TYPE_MEM_RD, 4'hF, 4'hF, 3'($random(seed)), 1'b0, 1'b0);
		repeat (2) @(posedge clk);
		chk_val("full", 16'h0001, 16'(full));
		pktq.push_back({1'b0, rqp_pkg::TYPE_MEM_RD, 4'hF, 4'hF});
		tagq.push_back(6'h09);
		offs[9] = 3'h2;
		fork
			u_user.send(rqp_pkg::TYPE_MEM_RD, 4'hF, 4'hF, 3'h2, 1'b0, 1'b0, '1);
			begin
				repeat (6) @(posedge clk);
				chk_val("ready", 16'h0000, 16'(ready));
				cfree <= 1'b1;
				ctag <= 6'h09;
				@(posedge clk);
				cfree <= 1'b0;
			end
		join
		for (int k = 0; k < 64; k++)
		begin
			ltag <= 6'(k);
			repeat (2) @(posedge clk);
			chk_val("align", 16'(offs[k]), 16'(calign));
		end
		for (int k = 0; k < 64; k++)
		begin
			cfree <= 1'b1;
			ctag <= 6'(k);
			busy[k] = 1'b0;
			@(posedge clk);
		end
		cfree <= 1'b0;
		repeat (2) @(posedge clk);
		chk_val("full", 16'h0000, 16'(full));
		req(rqp_pkg::TYPE_IO_RD, 4'h3, 4'h0, 3'h1, 1'b0, 1'b0);
		repeat (4) @(posedge clk);
		chk_val("errors", 16'h0001, 16'(errs));
		chk_val("pending", 16'h0000, 16'(pktq.size() + tagq.size()));
		final_report();
	end
endmodule : rqp_request_port_tb_top
